// [rtl/power_mode_clock_select.sv]
// Power mode control registers, mode sequencing and module standby outputs.
// Assumes a one-cycle sleep pulse and wake pulse from the core, one clock domain.
//
// Behaviour
// - Mode bits plus standby select pick target
// - No direct: standby, sleep or subsleep; wake
// - Direct transfer: straight to subactive or active
// - Active divider: 0XX undivided, else 8..64
// - Active divider applies only after sleep
// - Sub divider 8, 4, 2; applies after sleep
// - Standby register top bit reads zero
// - Bits 6,5,4 park two-wire, serial, converter
// - Bits 2,1,0 park timers W, V, A
`timescale 1ns/1ps
`include "pwr_clk_regs.svh"
module power_mode_clock_select (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_sleep_exec,
  input wire logic i_wake_irq,
  input wire logic i_wdt_on_int_osc,
  output logic [7:0] o_rdata,
  output logic [4:0] o_mode,
  output logic o_cpu_halted,
  output logic [2:0] o_active_shift,
  output logic [1:0] o_sub_shift,
  output logic [6:0] o_module_standby
);

  pwr_clk_pkg::reg_req_t req;
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // ************************************************************
  // Register file
  // ************************************************************
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [6:0] stby_ff;
  logic [6:0] nxt_stby;
  logic comp_standby_select_ff;
  logic nxt_comp_standby_select;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  pwr_clk_pkg::op_mode_t mode_ff;
  pwr_clk_pkg::op_mode_t nxt_mode;

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_stby = stby_ff;
    nxt_comp_standby_select = comp_standby_select_ff;
    nxt_rdata = `UNMAPPED_READ;
    if (req.wr)
    begin
      if (req.addr == `OFS_POWER_MODE_CLOCK_CONTROL)
      begin
        nxt_ctrl = req.wdata;
      end
      else if (req.addr == `OFS_PERIPHERAL_STANDBY_CONTROL)
      begin
        // Top bit has no storage at all
        nxt_stby = req.wdata[6:0];
      end
      else if (req.addr == `OFS_COMPANION_SYSTEM_CONTROL)
      begin
        nxt_comp_standby_select = req.wdata[`POS_STANDBY_SELECT];
      end
    end
    if (req.rd)
    begin
      if (req.addr == `OFS_POWER_MODE_CLOCK_CONTROL)
      begin
        nxt_rdata = ctrl_ff;
      end
      else if (req.addr == `OFS_PERIPHERAL_STANDBY_CONTROL)
      begin
        nxt_rdata = {1'b0, stby_ff};
      end
      else if (req.addr == `OFS_COMPANION_SYSTEM_CONTROL)
      begin
        nxt_rdata = {comp_standby_select_ff, 7'h00};
      end
      else if (req.addr == `OFS_MODE_STATUS)
      begin
        nxt_rdata = {3'h0, mode_ff};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl_ff <= `RST_POWER_MODE_CLOCK_CONTROL;
      stby_ff <= 7'h00;
      comp_standby_select_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      stby_ff <= nxt_stby;
      comp_standby_select_ff <= nxt_comp_standby_select;
      rdata_ff <= nxt_rdata;
    end
  end

  // ************************************************************
  // Mode sequencing
  // ************************************************************
  logic sel_sleep;
  logic sel_low;
  logic sel_direct;
  logic sleep_taken;
  logic [4:0] mode_out_ff;
  logic halted_ff;
  logic [6:0] mstb_ff;
  logic [6:0] nxt_mstb;

  assign sel_sleep = ctrl_ff[`POS_SLEEP_SELECT];
  assign sel_low = ctrl_ff[`POS_LOW_SPEED];
  assign sel_direct = ctrl_ff[`POS_DIRECT_TRANSFER];

  always_comb
  begin
    nxt_mode = mode_ff;
    sleep_taken = 1'b0;
    case (mode_ff)
      pwr_clk_pkg::ST_ACTIVE, pwr_clk_pkg::ST_SUBACTIVE:
      begin
        if (i_sleep_exec)
        begin
          sleep_taken = 1'b1;
          if (sel_direct)
          begin
            if (sel_low)
            begin
              nxt_mode = pwr_clk_pkg::ST_SUBACTIVE;
            end
            else if (!sel_sleep)
            begin
              nxt_mode = pwr_clk_pkg::ST_ACTIVE;
            end
          end
          else if (comp_standby_select_ff)
          begin
            nxt_mode = pwr_clk_pkg::ST_STANDBY;
          end
          else if (sel_sleep)
          begin
            nxt_mode = pwr_clk_pkg::ST_SUBSLEEP;
          end
          else
          begin
            nxt_mode = pwr_clk_pkg::ST_SLEEP;
          end
        end
      end
      pwr_clk_pkg::ST_SLEEP, pwr_clk_pkg::ST_SUBSLEEP:
      begin
        if (i_wake_irq)
        begin
          nxt_mode = sel_low ? pwr_clk_pkg::ST_SUBACTIVE : pwr_clk_pkg::ST_ACTIVE;
        end
      end
      pwr_clk_pkg::ST_STANDBY:
      begin
        if (i_wake_irq)
        begin
          nxt_mode = pwr_clk_pkg::ST_ACTIVE;
        end
      end
      default:
      begin
        nxt_mode = pwr_clk_pkg::ST_ACTIVE;
      end
    endcase
  end

  // Watchdog on internal oscillator never parks
  always_comb
  begin
    nxt_mstb = stby_ff;
    if (i_wdt_on_int_osc)
    begin
      nxt_mstb[`POS_WATCHDOG_STANDBY] = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mode_ff <= pwr_clk_pkg::ST_ACTIVE;
      mode_out_ff <= 5'h01;
      halted_ff <= 1'b0;
      mstb_ff <= 7'h00;
    end
    else
    begin
      mode_ff <= nxt_mode;
      mode_out_ff <= nxt_mode;
      halted_ff <= (nxt_mode == pwr_clk_pkg::ST_SLEEP) ||
                   (nxt_mode == pwr_clk_pkg::ST_SUBSLEEP) ||
                   (nxt_mode == pwr_clk_pkg::ST_STANDBY);
      mstb_ff <= nxt_mstb;
    end
  end

  // Divider latched on the sleep itself, never on the register write
  clk_div_apply u_div (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_apply(sleep_taken),
    .i_active_sel(ctrl_ff[`POS_ACTIVE_DIV_HI:`POS_ACTIVE_DIV_LO]),
    .i_sub_sel(ctrl_ff[`POS_SUB_DIV_HI:`POS_SUB_DIV_LO]),
    .o_active_shift(o_active_shift),
    .o_sub_shift(o_sub_shift)
  );

  assign o_rdata = rdata_ff;
  assign o_mode = mode_out_ff;
  assign o_cpu_halted = halted_ff;
  assign o_module_standby = mstb_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_direct_low;
    @(posedge i_clk) disable iff (!i_rstn)
    (mode_ff == pwr_clk_pkg::ST_ACTIVE && i_sleep_exec && sel_direct && sel_low)
    |=> (o_mode == 5'h04) && !o_cpu_halted;
  endproperty
  a_direct_low: assert property (p_direct_low) else $error("direct low-speed not subactive");

  property p_standby_sel;
    @(posedge i_clk) disable iff (!i_rstn)
    (mode_ff == pwr_clk_pkg::ST_ACTIVE && i_sleep_exec && !sel_direct && comp_standby_select_ff)
    |=> (o_mode == 5'h10) && o_cpu_halted;
  endproperty
  a_standby_sel: assert property (p_standby_sel) else $error("standby not entered");

  property p_sleep_sel;
    @(posedge i_clk) disable iff (!i_rstn)
    (mode_ff == pwr_clk_pkg::ST_ACTIVE && i_sleep_exec && !sel_direct && !comp_standby_select_ff)
    |=> o_mode == ($past(sel_sleep) ? 5'h08 : 5'h02);
  endproperty
  a_sleep_sel: assert property (p_sleep_sel) else $error("wrong sleep mode");

  property p_standby_wake;
    @(posedge i_clk) disable iff (!i_rstn)
    (mode_ff == pwr_clk_pkg::ST_STANDBY && i_wake_irq) |=> o_mode == 5'h01;
  endproperty
  a_standby_wake: assert property (p_standby_wake) else $error("standby wake not active");

  property p_div_hold;
    @(posedge i_clk) disable iff (!i_rstn)
    !sleep_taken |=> $stable(o_active_shift) && $stable(o_sub_shift);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider changed without sleep");

  property p_div_code;
    @(posedge i_clk) disable iff (!i_rstn)
    sleep_taken |=> o_active_shift == ($past(ctrl_ff[4]) ? 3'h3 + 3'($past(ctrl_ff[3:2])) : 3'h0)
      && o_sub_shift == ($past(ctrl_ff[1]) ? 2'h1 : ($past(ctrl_ff[0]) ? 2'h2 : 2'h3));
  endproperty
  a_div_code: assert property (p_div_code) else $error("divider code wrong");

  property p_resv_zero;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_rd && i_addr == `OFS_PERIPHERAL_STANDBY_CONTROL) |=> !o_rdata[7];
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bit reads one");

  property p_stby_follow;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_wr && i_addr == `OFS_PERIPHERAL_STANDBY_CONTROL) ##1 !i_wdt_on_int_osc
    |=> o_module_standby == $past(i_wdata[6:0], 2);
  endproperty
  a_stby_follow: assert property (p_stby_follow) else $error("standby outputs wrong");

  property p_wdt_int;
    @(posedge i_clk) disable iff (!i_rstn)
    i_wdt_on_int_osc |=> !o_module_standby[3];
  endproperty
  a_wdt_int: assert property (p_wdt_int) else $error("watchdog parked on internal osc");

  c_sleep: cover property (@(posedge i_clk) disable iff (!i_rstn) o_mode == 5'h02);
  c_subsleep: cover property (@(posedge i_clk) disable iff (!i_rstn) o_mode == 5'h08);
  c_standby_wake: cover property (@(posedge i_clk) disable iff (!i_rstn)
    o_mode == 5'h10 ##1 o_mode == 5'h01);
  c_subactive: cover property (@(posedge i_clk) disable iff (!i_rstn) o_mode == 5'h04);

endmodule

// [rtl/pwr_clk_regs.svh]
// Offsets, field positions, reset values and encodings of the power mode block.
// Assumes inclusion from the package and the design modules by bare name.
`ifndef PWR_CLK_REGS_SVH
`define PWR_CLK_REGS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_POWER_MODE_CLOCK_CONTROL 4'h0
`define OFS_PERIPHERAL_STANDBY_CONTROL 4'h1
`define OFS_COMPANION_SYSTEM_CONTROL 4'h2
`define OFS_MODE_STATUS 4'h3

// ************************************************************
// Field positions
// ************************************************************
`define POS_SLEEP_SELECT 7
`define POS_LOW_SPEED 6
`define POS_DIRECT_TRANSFER 5
`define POS_ACTIVE_DIV_HI 4
`define POS_ACTIVE_DIV_LO 2
`define POS_SUB_DIV_HI 1
`define POS_SUB_DIV_LO 0
`define POS_STANDBY_SELECT 7
`define POS_STANDBY_RESERVED 7
`define MASK_STANDBY_WRITABLE 8'h7F
`define POS_WATCHDOG_STANDBY 3

// ************************************************************
// Reset values
// ************************************************************
`define RST_POWER_MODE_CLOCK_CONTROL 8'h00
`define RST_PERIPHERAL_STANDBY_CONTROL 8'h00
`define RST_COMPANION_SYSTEM_CONTROL 8'h00
`define RST_ACTIVE_SHIFT 3'h0
`define RST_SUB_SHIFT 2'h3

// ************************************************************
// Unmapped read answer
// ************************************************************
`define UNMAPPED_READ 8'h00

`endif

// [rtl/pwr_clk_pkg.sv]
// Types shared by the power mode and clock select block.
// Assumes the constants header lives beside it.
`include "pwr_clk_regs.svh"
package pwr_clk_pkg;

  typedef enum logic [4:0] {
    ST_ACTIVE    = 5'h01,
    ST_SLEEP     = 5'h02,
    ST_SUBACTIVE = 5'h04,
    ST_SUBSLEEP  = 5'h08,
    ST_STANDBY   = 5'h10
  } op_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic two_wire_unit_standby;
    logic serial_unit_standby;
    logic converter_standby;
    logic watchdog_standby;
    logic timer_w_standby;
    logic timer_v_standby;
    logic timer_a_standby;
  } standby_vec_t;

endpackage

// [rtl/clk_div_apply.sv]
// Applied clock divider held in force until the sleep instruction runs.
// Assumes one clock and a one-cycle sleep pulse from the core.
`timescale 1ns/1ps
`include "pwr_clk_regs.svh"
module clk_div_apply (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_apply,
  input wire logic [2:0] i_active_sel,
  input wire logic [1:0] i_sub_sel,
  output logic [2:0] o_active_shift,
  output logic [1:0] o_sub_shift
);

  logic [2:0] active_shift_ff;
  logic [2:0] nxt_active_shift;
  logic [1:0] sub_shift_ff;
  logic [1:0] nxt_sub_shift;

  // Active divide as power of two: 0XX undivided, 100..111 give 8..64
  function automatic logic [2:0] active_shift(input logic [2:0] sel);
    if (sel[2] == 1'b0)
    begin
      active_shift = 3'h0;
    end
    else
    begin
      active_shift = 3'h3 + {1'b0, sel[1:0]};
    end
  endfunction

  // Sub divide as power of two: 00 eight, 01 four, 1X two
  function automatic logic [1:0] sub_shift(input logic [1:0] sel);
    if (sel[1])
    begin
      sub_shift = 2'h1;
    end
    else if (sel[0])
    begin
      sub_shift = 2'h2;
    end
    else
    begin
      sub_shift = 2'h3;
    end
  endfunction

  always_comb
  begin
    nxt_active_shift = active_shift_ff;
    nxt_sub_shift = sub_shift_ff;
    if (i_apply)
    begin
      nxt_active_shift = active_shift(i_active_sel);
      nxt_sub_shift = sub_shift(i_sub_sel);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      active_shift_ff <= `RST_ACTIVE_SHIFT;
      sub_shift_ff <= `RST_SUB_SHIFT;
    end
    else
    begin
      active_shift_ff <= nxt_active_shift;
      sub_shift_ff <= nxt_sub_shift;
    end
  end

  assign o_active_shift = active_shift_ff;
  assign o_sub_shift = sub_shift_ff;

endmodule

// [tb/tb_top.sv]
// Self-checking bench for the power mode and clock select block.
// Assumes the design files and the constants header compile first; one clock.
`timescale 1ns/1ps
`include "pwr_clk_regs.svh"
module tb_top;
  logic i_clk;
  logic i_rstn;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic i_sleep_exec;
  logic i_wake_irq;
  logic i_wdt_on_int_osc;
  logic [7:0] o_rdata;
  logic [4:0] o_mode;
  logic o_cpu_halted;
  logic [2:0] o_active_shift;
  logic [1:0] o_sub_shift;
  logic [6:0] o_module_standby;
  int num_errors = 0;
  int n_tests = 0;
  logic [7:0] exp_q[$];
  logic [7:0] exp_rd;
  logic rd_pend = 1'b0;
  logic [2:0] exp_act;
  logic [1:0] exp_sub;
  logic [6:0] exp_sby;
  logic [7:0] v;
  // Each row starts from where the previous row woke up
  // Last row: direct transfer with no target leaves the mode alone
  logic [7:0] t_comp [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80,
                              8'h00, 8'h00, 8'h80, 8'h80, 8'h00};
  logic [7:0] t_ctrl [10] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'hC0,
                              8'h60, 8'h20, 8'hE0, 8'h20, 8'hA0};
  logic [4:0] t_m1 [10] = '{5'h02, 5'h02, 5'h08, 5'h08, 5'h10,
                            5'h04, 5'h01, 5'h04, 5'h01, 5'h01};
  logic [4:0] t_m2 [10] = '{5'h01, 5'h04, 5'h01, 5'h04, 5'h01,
                            5'h04, 5'h01, 5'h04, 5'h01, 5'h01};

  power_mode_clock_select power_mode_clock_select_inst (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_sleep_exec(i_sleep_exec),
    .i_wake_irq(i_wake_irq),
    .i_wdt_on_int_osc(i_wdt_on_int_osc),
    .o_rdata(o_rdata),
    .o_mode(o_mode),
    .o_cpu_halted(o_cpu_halted),
    .o_active_shift(o_active_shift),
    .o_sub_shift(o_sub_shift),
    .o_module_standby(o_module_standby)
  );

  // ************************************************************
  // Clock and shared tasks
  // ************************************************************
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (num_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask

  task automatic pulse(input bit wake);
    @(posedge i_clk);
    if (wake)
      i_wake_irq <= 1'b1;
    else
      i_sleep_exec <= 1'b1;
    @(posedge i_clk);
    i_wake_irq <= 1'b0;
    i_sleep_exec <= 1'b0;
    settle(2);
  endtask

  task automatic chk_out(input logic [4:0] m);
    check("mode", {3'h0, o_mode}, {3'h0, m});
    check("halted", {7'h0, o_cpu_halted}, {7'h0, (m & 5'h1A) != 5'h00});
    check("active_shift", {5'h0, o_active_shift}, {5'h0, exp_act});
    check("sub_shift", {6'h0, o_sub_shift}, {6'h0, exp_sub});
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    settle(1);
    exp_act = 3'h0;
    exp_sub = 2'h3;
    chk_out(5'h01);
    check("standby", {1'b0, o_module_standby}, 8'h00);
    reg_rd(`OFS_POWER_MODE_CLOCK_CONTROL, 8'h00);
    reg_rd(`OFS_PERIPHERAL_STANDBY_CONTROL, 8'h00);
    reg_rd(`OFS_COMPANION_SYSTEM_CONTROL, 8'h00);
    reg_rd(`OFS_MODE_STATUS, 8'h01);
  endtask

  // ************************************************************
  // Read data monitor
  // ************************************************************
  // Held in reset: no read pending, flops may be unknown at time zero
  always @(posedge i_clk)
  begin
    if (i_rstn !== 1'b1)
      rd_pend <= 1'b0;
    else if (rd_pend === 1'b1)
    begin
      exp_rd = exp_q.pop_front();
      check("rdata", o_rdata, exp_rd);
      rd_pend <= i_rd;
    end
    else
    begin
      check("rdata_idle", o_rdata, 8'h00);
      rd_pend <= i_rd;
    end
  end

  // Hang guard, far beyond the real run length
  initial
  begin
    #400000;
    num_errors++;
    summarize();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    i_rstn = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_sleep_exec = 1'b0;
    i_wake_irq = 1'b0;
    i_wdt_on_int_osc = 1'b0;
    void'($urandom(3921));
    do_reset();
    // Every divider code, direct transfer keeps the core running
    for (int a = 0; a < 8; a++)
      for (int s = 0; s < 4; s++)
      begin
        v = {3'h1, a[2:0], s[1:0]};
        reg_wr(`OFS_POWER_MODE_CLOCK_CONTROL, v);
        reg_rd(`OFS_POWER_MODE_CLOCK_CONTROL, v);
        settle(2);
        chk_out(5'h01);
        pulse(1'b0);
        exp_act = a[2] ? {1'b0, a[1:0]} + 3'h3 : 3'h0;
        exp_sub = s[1] ? 2'h1 : (s[0] ? 2'h2 : 2'h3);
        chk_out(5'h01);
      end
    exp_act = 3'h0;
    exp_sub = 2'h3;
    // Mode selection, refused sleep while halted, refused wake while running
    for (int i = 0; i < 10; i++)
    begin
      reg_wr(`OFS_COMPANION_SYSTEM_CONTROL, t_comp[i]);
      reg_wr(`OFS_POWER_MODE_CLOCK_CONTROL, t_ctrl[i]);
      pulse(1'b0);
      chk_out(t_m1[i]);
      reg_rd(`OFS_MODE_STATUS, {3'h0, t_m1[i]});
      pulse(1'b0);
      chk_out(t_m1[i]);
      pulse(1'b1);
      chk_out(t_m2[i]);
      pulse(1'b1);
      chk_out(t_m2[i]);
    end
    // Module standby bits, reserved bit and watchdog exception
    for (int i = 0; i < 14; i++)
    begin
      v = (i == 0) ? 8'hFF : 8'($urandom());
      @(posedge i_clk);
      i_wdt_on_int_osc <= (i == 1) ? 1'b1 : 1'($urandom());
      reg_wr(`OFS_PERIPHERAL_STANDBY_CONTROL, v);
      reg_rd(`OFS_PERIPHERAL_STANDBY_CONTROL, v & 8'h7F);
      settle(3);
      exp_sby = v[6:0];
      if (i_wdt_on_int_osc === 1'b1)
        exp_sby[3] = 1'b0;
      check("standby", {1'b0, o_module_standby}, {1'b0, exp_sby});
    end
    reg_wr(`OFS_PERIPHERAL_STANDBY_CONTROL, 8'h00);
    settle(3);
    check("standby_clr", {1'b0, o_module_standby}, 8'h00);
    // Unmapped place is inert and reads zero
    reg_wr(`OFS_POWER_MODE_CLOCK_CONTROL, 8'h1D);
    reg_wr(4'h9, 8'hFF);
    reg_rd(4'h9, 8'h00);
    reg_rd(`OFS_POWER_MODE_CLOCK_CONTROL, 8'h1D);
    reg_rd(`OFS_PERIPHERAL_STANDBY_CONTROL, 8'h00);
    // Second reset in mid-run
    reg_wr(`OFS_PERIPHERAL_STANDBY_CONTROL, 8'h55);
    pulse(1'b0);
    do_reset();
    settle(3);
    summarize();
  end
endmodule
